/* File: rtl/tmr_pkg.sv */
// Constants for the Timer 0/1 mode logic and the Timer 2 control block.
// Assumes a byte-wide special-function-register bus on the core clock.
// Contract
// - Gate bit adds external-input level to run condition
// - Counter select 1 counts count-pin falling edges
// - Counter select 0 counts the chosen internal clock
// - Mode 0 13-bit, 1 16-bit, 2 8-bit reload
// - Timer 1 mode 3 stops Timer 1
// - Timer 0 mode 3 is two 8-bit timers
// - Count bytes readable, writable, reset to zero
// - Timer 2 low byte rollover sets low flag
// - Low flag set every mode, cleared only by firmware
// - Low flag with enable raises Timer 2 interrupt
// - Capture copies 16-bit count into reload pair
// - Reload pair supplies reload value on rollover; non-split capture mode rolls to zero instead
// - In capture mode reload pair holds captured count
// - Capture source field picks the capture trigger
// - Split mode high and low bytes are separate timers
package tmr_pkg;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_T0L = 8'h8A;
    localparam logic [7:0] ADDR_T1L = 8'h8B;
    localparam logic [7:0] ADDR_T0H = 8'h8C;
    localparam logic [7:0] ADDR_T1H = 8'h8D;
    localparam logic [7:0] ADDR_T2CTRL = 8'hC8;
    localparam logic [7:0] ADDR_T2RLL = 8'hCA;
    localparam logic [7:0] ADDR_T2RLH = 8'hCB;
    localparam logic [7:0] ADDR_T2L = 8'hCC;
    localparam logic [7:0] ADDR_T2H = 8'hCD;
    localparam logic [7:0] ADDR_T2_CAPTURE_SOURCE = 8'hFD;

    // Mode register fields
    localparam int B_T1_GATE_CTRL = 7;
    localparam int B_CT1 = 6;
    localparam int B_T1M = 4;
    localparam int B_T0_GATE_CTRL = 3;
    localparam int B_CT0 = 2;
    localparam int B_T0M = 0;

    // Timer 2 control fields
    localparam int B_T2HF = 7;
    localparam int B_T2LF = 6;
    localparam int B_T2LIEN = 5;
    localparam int B_T2CEN = 4;
    localparam int B_T2_SPLIT_SELECT = 3;
    localparam int B_T2RUN = 2;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_CSEL = 3'h0;
    localparam logic [7:0] BYTE_MAX = 8'hFF;

    typedef enum logic [1:0] {
        TMR_MODE13 = 2'b00,
        TMR_MODE16 = 2'b01,
        TMR_MODE8R = 2'b10,
        TMR_MODE3 = 2'b11
    } tmr_mode_t;

    typedef enum logic [2:0] {
        TMR_CAP_PIN = 3'b000,
        TMR_CAP_LFO = 3'b001,
        TMR_CAP_CMP0 = 3'b010,
        TMR_CAP_SOF = 3'b011
    } tmr_csel_t;
endpackage

/* File: rtl/tmr_t2_if.sv */
// Signals between the register front end and the Timer 2 core.
// Assumes both ends sit on the same core clock.
interface tmr_t2_if;
    logic wr_ctrl;
    logic wr_rll;
    logic wr_rlh;
    logic wr_cl;
    logic wr_ch;
    logic [7:0] wdata;
    logic tick;
    logic cap_evt;
    logic [7:0] ctrl;
    logic [7:0] rll;
    logic [7:0] rlh;
    logic [7:0] cl;
    logic [7:0] ch;
    logic irq_req;
    modport front (output wr_ctrl, wr_rll, wr_rlh, wr_cl, wr_ch, wdata, tick, cap_evt,
                   input ctrl, rll, rlh, cl, ch, irq_req);
    modport core (input wr_ctrl, wr_rll, wr_rlh, wr_cl, wr_ch, wdata, tick, cap_evt,
                  output ctrl, rll, rlh, cl, ch, irq_req);
endinterface

/* File: rtl/tmr_t2.sv */
// Timer 2 core: control register, count bytes, reload pair, capture.
// Assumes write strobes are single-cycle and decoded by the front end.
module tmr_t2
    import tmr_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    tmr_t2_if.core bus // Front-end link
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rll;
        logic [7:0] rlh;
        logic [7:0] cl;
        logic [7:0] ch;
    } tmr_t2_st_t;

    tmr_t2_st_t st;
    tmr_t2_st_t next_st;

    always_comb begin
        logic set_h;
        logic set_l;
        logic cen;
        logic [15:0] cnt;
        next_st = st;
        set_h = 1'b0;
        set_l = 1'b0;
        cen = st.ctrl[B_T2CEN];
        cnt = {st.ch, st.cl};
        if (st.ctrl[B_T2_SPLIT_SELECT]) begin
            // Low byte ignores run bit in split operation
            if (bus.tick) begin
                set_l = (st.cl == BYTE_MAX);
                next_st.cl = set_l ? st.rll : st.cl + 8'h01;
            end
            if (bus.tick && st.ctrl[B_T2RUN]) begin
                set_h = (st.ch == BYTE_MAX);
                next_st.ch = set_h ? st.rlh : st.ch + 8'h01;
            end
        end else if (bus.tick && st.ctrl[B_T2RUN]) begin
            set_l = (st.cl == BYTE_MAX);
            set_h = (cnt == 16'hFFFF);
            // Capture mode free-runs through zero so captures stay meaningful
            if (set_h) begin
                {next_st.ch, next_st.cl} = cen ? 16'h0000 : {st.rlh, st.rll};
            end else begin
                {next_st.ch, next_st.cl} = cnt + 16'h0001;
            end
        end
        if (cen && bus.cap_evt) begin
            next_st.rlh = st.ch;
            next_st.rll = st.cl;
            set_h = 1'b1;
        end
        if (bus.wr_rll) begin
            next_st.rll = bus.wdata;
        end
        if (bus.wr_rlh) begin
            next_st.rlh = bus.wdata;
        end
        if (bus.wr_cl) begin
            next_st.cl = bus.wdata;
        end
        if (bus.wr_ch) begin
            next_st.ch = bus.wdata;
        end
        // Hardware set beats a firmware clear in the same cycle
        next_st.ctrl = bus.wr_ctrl ? bus.wdata : st.ctrl;
        next_st.ctrl[B_T2HF] = next_st.ctrl[B_T2HF] | set_h;
        next_st.ctrl[B_T2LF] = next_st.ctrl[B_T2LF] | set_l;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.ctrl = st.ctrl;
    assign bus.rll = st.rll;
    assign bus.rlh = st.rlh;
    assign bus.cl = st.cl;
    assign bus.ch = st.ch;
    assign bus.irq_req = st.ctrl[B_T2HF]
        | (st.ctrl[B_T2LF] & st.ctrl[B_T2LIEN]);
endmodule

/* File: rtl/tmr_top.sv */
// Timer 0/1 mode and count logic, register front end and Timer 2 link.
// Assumes all pins are synchronous to core_clk and that the run bits,
// clock selects and interrupt polarities come from registers outside.
module tmr_top
    import tmr_pkg::*;
(
    input wire logic core_clk, // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [7:0] sfr_addr, // Register address
    input wire logic sfr_wr, // Write strobe
    input wire logic sfr_rd, // Read strobe
    input wire logic [7:0] sfr_wdata, // Write data
    output logic [7:0] sfr_rdata, // Read data, one cycle after strobe
    input wire logic t0_run, // Timer 0 run bit
    input wire logic t1_run, // Timer 1 run bit
    input wire logic ext_irq0_input, // External interrupt 0 pin
    input wire logic ext_irq1_input, // External interrupt 1 pin
    input wire logic ext_irq0_polarity, // 1: input 0 active high
    input wire logic ext_irq1_polarity, // 1: input 1 active high
    input wire logic t0_use_sysclk, // Timer 0 clock: 1 system, 0 prescaled
    input wire logic t1_use_sysclk, // Timer 1 clock: 1 system, 0 prescaled
    input wire logic prescale_tick, // Prescaler enable pulse
    input wire logic t0_count_pin, // Timer 0 count pin
    input wire logic t1_count_pin, // Timer 1 count pin
    input wire logic t2_tick, // Timer 2 clock enable pulse
    input wire logic t2_capture_pin, // Timer 2 capture pin
    input wire logic lfo_clk_in, // Low-frequency oscillator level
    input wire logic cmp0_out, // Comparator 0 output
    input wire logic usb_sof_evt, // Start-of-frame pulse
    input wire logic t2_irq_enable, // Timer 2 interrupts enabled
    output logic t0_overflow, // Timer 0 overflow pulse
    output logic t1_overflow, // Timer 1 overflow pulse
    output logic t2_irq // Timer 2 interrupt request level
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] t0l;
        logic [7:0] t0h;
        logic [7:0] t1l;
        logic [7:0] t1h;
        logic [2:0] csel;
        logic [7:0] rdata;
        logic t0_ovf;
        logic t1_ovf;
        logic t2_irq;
        logic [4:0] prev;
    } tmr_top_st_t;

    tmr_top_st_t st;
    tmr_top_st_t next_st;
    tmr_t2_if t2 ();

    tmr_t2 u_t2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus(t2.core)
    );

    // Returns {overflow, high, low} after one count step
    function automatic logic [16:0] tmr_step(tmr_mode_t m, logic [7:0] lo, logic [7:0] hi);
        logic [16:0] r;
        logic [13:0] s13;
        logic [8:0] s9;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s9 = {1'b0, lo} + 9'h001;
        case (m)
            TMR_MODE13: begin
                r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
            end
            TMR_MODE16: begin
                r = {1'b0, hi, lo} + 17'h00001;
            end
            TMR_MODE8R: begin
                r = {s9[8], hi, s9[8] ? hi : s9[7:0]};
            end
            default: begin
                r = {s9[8], hi, s9[7:0]};
            end
        endcase
        return r;
    endfunction

    logic [4:0] pins;
    logic [4:0] fall;
    tmr_mode_t m0;
    tmr_mode_t m1;
    logic run0;
    logic run1;
    logic tick0;
    logic tick1;
    logic tick0h;
    logic [16:0] r0;
    logic [16:0] r1;
    logic [8:0] r0h;
    logic cap_evt;

    // Pins are taken as already synchronous; one register finds edges
    assign pins = {cmp0_out, lfo_clk_in, t2_capture_pin, t1_count_pin, t0_count_pin};
    assign fall = st.prev & ~pins;
    assign m0 = tmr_mode_t'(st.mode[B_T0M +: 2]);
    assign m1 = tmr_mode_t'(st.mode[B_T1M +: 2]);

    always_comb begin
        run0 = t0_run
            & (~st.mode[B_T0_GATE_CTRL] | (ext_irq0_input == ext_irq0_polarity));
        run1 = t1_run
            & (~st.mode[B_T1_GATE_CTRL] | (ext_irq1_input == ext_irq1_polarity));
        tick0 = run0 & (st.mode[B_CT0] ? fall[0]
            : (t0_use_sysclk | prescale_tick));
        tick1 = run1 & (m1 != TMR_MODE3) & (st.mode[B_CT1] ? fall[1]
            : (t1_use_sysclk | prescale_tick));
        // Upper half of split Timer 0 borrows Timer 1's run bit, timer clock only
        tick0h = (m0 == TMR_MODE3) & t1_run & (t0_use_sysclk | prescale_tick);
        r0 = tmr_step(m0, st.t0l, st.t0h);
        r1 = tmr_step(m1, st.t1l, st.t1h);
        r0h = {1'b0, st.t0h} + 9'h001;
    end

    always_comb begin
        case (tmr_csel_t'(st.csel))
            TMR_CAP_PIN: cap_evt = fall[2];
            TMR_CAP_LFO: cap_evt = fall[3];
            TMR_CAP_CMP0: cap_evt = fall[4];
            TMR_CAP_SOF: cap_evt = usb_sof_evt;
            default: cap_evt = 1'b0;
        endcase
    end

    assign t2.tick = t2_tick;
    assign t2.cap_evt = cap_evt;
    assign t2.wdata = sfr_wdata;
    assign t2.wr_ctrl = sfr_wr && (sfr_addr == ADDR_T2CTRL);
    assign t2.wr_rll = sfr_wr && (sfr_addr == ADDR_T2RLL);
    assign t2.wr_rlh = sfr_wr && (sfr_addr == ADDR_T2RLH);
    assign t2.wr_cl = sfr_wr && (sfr_addr == ADDR_T2L);
    assign t2.wr_ch = sfr_wr && (sfr_addr == ADDR_T2H);

    always_comb begin
        next_st = st;
        next_st.prev = pins;
        next_st.t0_ovf = 1'b0;
        next_st.t1_ovf = 1'b0;

        if (tick0) begin
            next_st.t0l = r0[7:0];
            if (m0 != TMR_MODE3) begin
                next_st.t0h = r0[15:8];
            end
            next_st.t0_ovf = r0[16];
        end
        if (tick0h) begin
            next_st.t0h = r0h[7:0];
            next_st.t1_ovf = r0h[8];
        end
        if (tick1) begin
            next_st.t1l = r1[7:0];
            next_st.t1h = r1[15:8];
            next_st.t1_ovf = r1[16];
        end

        // A firmware write takes precedence over a count in the same cycle
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_MODE: next_st.mode = sfr_wdata;
                ADDR_T0L: next_st.t0l = sfr_wdata;
                ADDR_T1L: next_st.t1l = sfr_wdata;
                ADDR_T0H: next_st.t0h = sfr_wdata;
                ADDR_T1H: next_st.t1h = sfr_wdata;
                ADDR_T2_CAPTURE_SOURCE: next_st.csel = sfr_wdata[2:0];
                default: next_st.csel = next_st.csel;
            endcase
        end

        // Read data holds until the next read; unmapped reads return zero
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_MODE: next_st.rdata = st.mode;
                ADDR_T0L: next_st.rdata = st.t0l;
                ADDR_T1L: next_st.rdata = st.t1l;
                ADDR_T0H: next_st.rdata = st.t0h;
                ADDR_T1H: next_st.rdata = st.t1h;
                ADDR_T2CTRL: next_st.rdata = t2.ctrl;
                ADDR_T2RLL: next_st.rdata = t2.rll;
                ADDR_T2RLH: next_st.rdata = t2.rlh;
                ADDR_T2L: next_st.rdata = t2.cl;
                ADDR_T2H: next_st.rdata = t2.ch;
                ADDR_T2_CAPTURE_SOURCE: next_st.rdata = {5'h00, st.csel};
                default: next_st.rdata = RST_BYTE;
            endcase
        end

        next_st.t2_irq = t2_irq_enable & t2.irq_req;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign t0_overflow = st.t0_ovf;
    assign t1_overflow = st.t1_ovf;
    assign t2_irq = st.t2_irq;
endmodule

/* File: tb/tmr_props.sv */
// Checker for the timer block, watching the top-level ports only.
// Assumes the bind in tb_top and the shared constant package.
module tmr_props
    import tmr_pkg::*;
(
    input logic core_clk, // Clock
    input logic rst_n, // Reset
    input logic [7:0] sfr_addr, // Address
    input logic sfr_wr, // Write
    input logic sfr_rd, // Read
    input logic [7:0] sfr_wdata, // Write data
    input logic [7:0] sfr_rdata, // Read data
    input logic t0_run, // Run 0
    input logic t1_run, // Run 1
    input logic ext_irq0_input, // Gate 0
    input logic ext_irq1_input, // Gate 1
    input logic ext_irq0_polarity, // Level 0
    input logic ext_irq1_polarity, // Level 1
    input logic t2_tick, // Timer 2 tick
    input logic t2_irq_enable, // Timer 2 enable
    input logic t0_overflow, // Pulse 0
    input logic t1_overflow, // Pulse 1
    input logic t2_irq // Timer 2 request
);
    logic [7:0] md;
    wire ctrl_wr = sfr_wr && sfr_addr == ADDR_T2CTRL;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Mirror of the mode register, qualifies the count checks
    always_ff @(posedge core_clk) begin
        if (!rst_n) md <= 8'h00;
        else if (sfr_wr && sfr_addr == ADDR_MODE) md <= sfr_wdata;
    end
    property p_rst_zero; $rose(rst_n) |-> sfr_rdata == 8'h00 && !t0_overflow && !t2_irq; endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("Outputs not zero after reset");
    property p_irq_en; t2_irq |-> $past(t2_irq_enable); endproperty
    a_irq_en: assert property (p_irq_en) else $error("Request without enable");
    // Three cycles cover the one-cycle delay of the overflow pulse
    property p_t1_stop; (md[5:4] == 2'b11 && md[1:0] != 2'b11)[*3] |-> !t1_overflow; endproperty
    a_t1_stop: assert property (p_t1_stop) else $error("Timer 1 ran in mode 3");
    property p_t0_gate_ctrl;
        (!t0_run || md[3] && ext_irq0_input != ext_irq0_polarity)[*3] |-> !t0_overflow;
    endproperty
    a_t0_gate_ctrl: assert property (p_t0_gate_ctrl) else $error("Timer 0 counted while held");
    property p_t1_gate_ctrl;
        (md[1:0] != 2'b11 && (!t1_run || md[7] && ext_irq1_input != ext_irq1_polarity))[*3]
            |-> !t1_overflow;
    endproperty
    a_t1_gate_ctrl: assert property (p_t1_gate_ctrl) else $error("Timer 1 counted while held");
    property p_flag_set; ctrl_wr && sfr_wdata[7] ##1 t2_irq_enable[*2] |-> t2_irq; endproperty
    a_flag_set: assert property (p_flag_set) else $error("High flag gave no request");
    property p_clear; ctrl_wr && sfr_wdata == 8'h00 && !t2_tick ##1 !ctrl_wr[*2] |-> !t2_irq; endproperty
    a_clear: assert property (p_clear) else $error("Request stayed after clear");
    property p_mode_rd; sfr_rd && sfr_addr == ADDR_MODE |=> sfr_rdata == $past(md); endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("Mode readback wrong");
    c_ov0: cover property (t0_overflow);
    c_ov1: cover property (t1_overflow);
    c_irq: cover property (t2_irq);
endmodule

/* File: tb/tmr_pin_model.sv */
// Far-side model of the Timer 0 count pin: bursts of falling edges.
// Assumes start is held for one cycle; the pin idles high.
module tmr_pin_model (
    input logic core_clk, // Clock
    input logic start, // Burst request
    input logic [7:0] n_fall, // Falls wanted
    output logic pin, // Count pin
    output logic busy // Burst running
);
    timeunit 1ns;
    timeprecision 1ps;
    logic go = 1'b0;
    logic [8:0] left = 9'h000;
    // Request taken on the rising edge to avoid a race with the bench
    always @(posedge core_clk) go <= start;
    always @(negedge core_clk) begin
        if (go) left <= {n_fall, 1'b0};
        else if (left != 9'h000) left <= left - 9'h001;
    end
    assign pin = ~left[0];
    assign busy = left != 9'h000;
endmodule

/* File: tb/tb_top.sv */
// Register-level bench for the timer block.
// Assumes the pin model drives the Timer 0 count pin.
module tb_top
    import tmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, t0_run = 1'b0;
    logic t1_run = 1'b0, ext0 = 1'b0, use0 = 1'b1, pre = 1'b0, t2_tick = 1'b0, t2_ie = 1'b0;
    logic pstart = 1'b0, t0_pin, pbusy, t0_ov, t1_ov, t2_irq;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, pn = 8'h03;
    logic [3:0] cap = 4'h0;
    logic [7:0] regs [0:10] = '{ADDR_MODE, ADDR_T0L, ADDR_T1L, ADDR_T0H, ADDR_T1H,
        ADDR_T2CTRL, ADDR_T2RLL, ADDR_T2RLH, ADDR_T2L, ADDR_T2H, ADDR_T2_CAPTURE_SOURCE};
    int n_mismatch = 0, n_compared = 0, ov0 = 0, ov1 = 0, cyc = 0;
    tmr_top dut (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .t0_run(t0_run),
        .t1_run(t1_run), .ext_irq0_input(ext0), .ext_irq1_input(1'b0),
        .ext_irq0_polarity(1'b1), .ext_irq1_polarity(1'b1), .t0_use_sysclk(use0),
        .t1_use_sysclk(1'b1), .prescale_tick(pre), .t0_count_pin(t0_pin), .t1_count_pin(1'b1),
        .t2_tick(t2_tick), .t2_capture_pin(cap[0]), .lfo_clk_in(cap[1]), .cmp0_out(cap[2]),
        .usb_sof_evt(cap[3]), .t2_irq_enable(t2_ie), .t0_overflow(t0_ov),
        .t1_overflow(t1_ov), .t2_irq(t2_irq));
    tmr_pin_model pins (.core_clk(core_clk), .start(pstart), .n_fall(pn), .pin(t0_pin),
        .busy(pbusy));
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        ov0 += int'(t0_ov === 1'b1);
        ov1 += int'(t1_ov === 1'b1);
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge core_clk);
        sfr_rd = 1'b0;
        @(negedge core_clk);
        chk(sfr_rdata, exp);
    endtask
    task automatic run0(input logic [7:0] m, lo, hi, input int n, input logic [7:0] elo, ehi, eov);
        wr(ADDR_MODE, m);
        wr(ADDR_T0L, lo);
        wr(ADDR_T0H, hi);
        ov0 = 0;
        t0_run = 1'b1;
        repeat (n) @(negedge core_clk);
        t0_run = 1'b0;
        rd(ADDR_T0L, elo);
        rd(ADDR_T0H, ehi);
        chk(8'(ov0), eov);
    endtask
    initial begin
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(ADDR_T1H, 8'hC3);
        rd(ADDR_T1H, 8'hC3);
        wr(ADDR_MODE, 8'h5A);
        rd(ADDR_MODE, 8'h5A);
        run0(8'h01, 8'hF0, 8'hFF, 16, 8'h00, 8'h00, 8'h01);
        run0(8'h00, 8'hFF, 8'hFF, 1, 8'hE0, 8'h00, 8'h01);
        run0(8'h02, 8'hFE, 8'hFC, 2, 8'hFC, 8'hFC, 8'h01);
        run0(8'h03, 8'hFE, 8'h10, 3, 8'h01, 8'h10, 8'h01);
        run0(8'h09, 8'h00, 8'h00, 5, 8'h00, 8'h00, 8'h00);
        ext0 = 1'b1;
        run0(8'h09, 8'h00, 8'h00, 5, 8'h05, 8'h00, 8'h00);
        use0 = 1'b0;
        run0(8'h01, 8'h00, 8'h00, 5, 8'h00, 8'h00, 8'h00);
        pre = 1'b1;
        run0(8'h01, 8'h00, 8'h00, 5, 8'h05, 8'h00, 8'h00);
        use0 = 1'b1;
        run0(8'h05, 8'h00, 8'h00, 1, 8'h00, 8'h00, 8'h00);
        t0_run = 1'b1;
        pstart = 1'b1;
        @(negedge core_clk);
        pstart = 1'b0;
        repeat (2) @(negedge core_clk);
        while (pbusy === 1'b1) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        t0_run = 1'b0;
        rd(ADDR_T0L, 8'h03);
        wr(ADDR_MODE, 8'h33);
        wr(ADDR_T0H, 8'hFE);
        ov1 = 0;
        t1_run = 1'b1;
        repeat (3) @(negedge core_clk);
        t1_run = 1'b0;
        rd(ADDR_T0H, 8'h01);
        rd(ADDR_T1L, 8'h00);
        chk(8'(ov1), 8'h01);
        // Timer 1 parked at all ones would wrap on its first tick if it ran
        wr(ADDR_T1L, 8'hFF);
        wr(ADDR_T1H, 8'hFF);
        wr(ADDR_MODE, 8'h30);
        ov1 = 0;
        t1_run = 1'b1;
        repeat (5) @(negedge core_clk);
        t1_run = 1'b0;
        rd(ADDR_T1L, 8'hFF);
        rd(ADDR_T1H, 8'hFF);
        chk(8'(ov1), 8'h00);
        wr(ADDR_T2RLL, 8'h34);
        wr(ADDR_T2RLH, 8'h12);
        wr(ADDR_T2L, 8'hFF);
        wr(ADDR_T2H, 8'hFF);
        wr(ADDR_T2CTRL, 8'h04);
        t2_tick = 1'b1;
        @(negedge core_clk);
        t2_tick = 1'b0;
        t2_ie = 1'b1;
        rd(ADDR_T2L, 8'h34);
        rd(ADDR_T2H, 8'h12);
        rd(ADDR_T2CTRL, 8'hC4);
        chk({7'h00, t2_irq}, 8'h01);
        wr(ADDR_T2CTRL, 8'h00);
        rd(ADDR_T2CTRL, 8'h00);
        chk({7'h00, t2_irq}, 8'h00);
        wr(ADDR_T2CTRL, 8'h80);
        wr(ADDR_T2RLL, 8'h80);
        wr(ADDR_T2L, 8'hFF);
        wr(ADDR_T2H, 8'hFF);
        wr(ADDR_T2CTRL, 8'h28);
        t2_tick = 1'b1;
        @(negedge core_clk);
        t2_tick = 1'b0;
        rd(ADDR_T2L, 8'h80);
        rd(ADDR_T2H, 8'hFF);
        rd(ADDR_T2CTRL, 8'h68);
        chk({7'h00, t2_irq}, 8'h01);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_T2_CAPTURE_SOURCE, 8'(s));
            wr(ADDR_T2L, 8'h10 + 8'(s));
            wr(ADDR_T2H, 8'hA5);
            wr(ADDR_T2CTRL, 8'h10);
            cap = 4'h1 << s;
            @(negedge core_clk);
            cap = 4'h0;
            rd(ADDR_T2_CAPTURE_SOURCE, 8'(s));
            rd(ADDR_T2RLL, 8'h10 + 8'(s));
            rd(ADDR_T2RLH, 8'hA5);
            rd(ADDR_T2CTRL, 8'h90);
        end
        complete_run();
    end
endmodule
bind tmr_top tmr_props u_props (.*);
